// [mees_error_status.sv]
/*
 * Memory ECC error status: syndrome check of reads and masked writes, sticky
 * error flags, prioritised syndrome capture, event interrupt and a
 * classic Wishbone slave. Assumes reference strobes come from the
 * memory controller on clk; dcPowerGood arrives from a pin.
 */
// Design decisions made here: the register offsets and the Wishbone slave port.
// Function
// (RULE_01) DMA reference error sets DMA flag
// (RULE_02) CPU write parity error sets parity flag
// (RULE_03) Flags clear only on writing one
// (RULE_04) Power-up or halted power-good drop clears
// (RULE_05) Read-only seven-bit syndrome field
// (RULE_06) Zero syndrome means no error
// (RULE_07) Each single-bit error has distinct syndrome
// (RULE_08) Unmatched non-zero syndrome is uncorrectable
// (RULE_09) Syndrome follows page-address capture priority
// (RULE_10) Check bit k gives one-hot syndrome
// (RULE_11) Parity error stores poisoned check bits
// (RULE_12) Data bits decode from fixed syndromes
// (RULE_13) Parity over uncorrectable over correctable
// (RULE_14) Word is 32 data plus 7 check
// (RULE_15) Syndrome is XOR; single error corrected
`timescale 1ns/1ps
module mees_error_status
   import mees_pkg::*;
(
   input  wire logic        clk,          // 200 MHz controller clock
   input  wire logic        reset_n,      // Asynchronous, active low
   input  wire logic        wb_cyc_i,     // Wishbone cycle
   input  wire logic        wb_stb_i,     // Wishbone strobe
   input  wire logic        wb_we_i,      // Wishbone write
   input  wire logic [3:0]  wb_adr_i,     // Byte address
   input  wire logic [3:0]  wb_sel_i,     // Byte lanes
   input  wire logic [31:0] wb_dat_i,     // Write data
   output logic      [31:0] wb_dat_o,     // Read data
   output logic             wb_ack_o,     // Acknowledge
   input  wire logic        refValid,     // One-cycle reference strobe
   input  wire logic        refDma,       // Reference made by DMA
   input  wire logic        refWrite,     // Write reference
   input  wire logic        refMasked,    // Masked write (read first)
   input  wire logic        busParErr,    // Bus parity failed
   input  wire logic [31:0] rdData,       // Array read data
   input  wire logic [6:0]  rdCheck,      // Array read check bits
   input  wire logic [31:0] wrData,       // Data to write
   input  wire logic        dcPowerGood,  // Pin, asynchronous
   input  wire logic        cpuHalted,    // Processor halted
   output logic             outValid,     // Results below are fresh
   output logic      [31:0] outData,      // Corrected read data
   output logic      [6:0]  outCheck,     // Check bits to store
   output logic             irq           // Level interrupt
);

   // ==========================================================
   // Declarations
   logic [6:0]  syn;                 // Syndrome of the read word
   logic        single;              // Correctable pattern
   logic [31:0] fixData;             // Repaired data
   logic        parBad;              // CPU write parity failure
   logic [6:0]  wrCheck;             // Encoded check bits
   logic        eccChk;              // Reference reads the array
   logic        eccErr;              // Any detectable ECC error
   logic        corrEv;              // Correctable event
   logic        uncorrEv;            // Uncorrectable event
   logic        dmaEv;               // Error on a DMA reference
   mees_level_t newLvl;              // Priority of this cycle's error
   mees_level_t curLvl;              // Priority already captured
   logic        capture;             // Take a new syndrome
   logic        dcokMeta_r;          // Synchroniser stage one
   logic        dcokSync_r;          // Synchroniser stage two
   logic        dcokLast_r;          // Delayed copy for edge detect
   logic        powerClr;            // Halted power-good negation
   logic        errDma_r;            // DMA error flag
   logic        errPar_r;            // Bus parity error flag
   logic [6:0]  synCap_r;            // Captured syndrome
   logic [3:0]  evStat_r;            // Sticky event bits
   logic [3:0]  evMask_r;            // Event mask
   logic        outValid_r;          // Result strobe
   logic [31:0] outData_r;           // Result data
   logic [6:0]  outCheck_r;          // Result check bits
   logic        ack_r;               // Bus acknowledge
   logic [31:0] rdMux_r;             // Registered read data
   logic        busReq;              // New bus request this cycle
   logic        wrStatus;            // Write to error status
   logic        wrEvStat;            // Write to event status
   logic        wrEvMask;            // Write to event mask

   // ==========================================================
   // Syndrome decode and write encode
   mees_syn_decode u_dec (
      .rdData    (rdData),
      .rdCheck   (rdCheck),   // see (RULE_14)
      .syndrome  (syn),
      .singleHit (single),
      .fixData   (fixData)
   );

   mees_write_encode u_enc (
      .wrData  (wrData),
      .parBad  (parBad),
      .wrCheck (wrCheck)
   );

   // ==========================================================
   // Event classification
   always_comb begin
      // DMA write parity is never checked
      parBad   = refValid && refWrite && !refDma && busParErr;
      // Reads and masked writes both fetch the stored word
      eccChk   = refValid && (!refWrite || refMasked);
      eccErr   = eccChk && (syn != MEES_SYN_RST);     // see (RULE_06)
      corrEv   = eccErr && single;                    // see (RULE_07)
      uncorrEv = eccErr && !single;                   // see (RULE_08)
      dmaEv    = refValid && refDma && eccErr;        // see (RULE_01)
   end

   // ==========================================================
   // Priority of the new error against what is held
   always_comb begin
      if (parBad) begin
         newLvl = MEES_LVL_PAR;                       // see (RULE_13)
      end else if (uncorrEv) begin
         newLvl = MEES_LVL_UNCORR;
      end else if (corrEv) begin
         newLvl = MEES_LVL_CORR;
      end else begin
         newLvl = MEES_LVL_NONE;
      end
      // Held level follows the sticky flags; clearing them re-arms
      if (errPar_r) begin
         curLvl = MEES_LVL_PAR;
      end else if (evStat_r[MEES_EV_UNCORR]) begin
         curLvl = MEES_LVL_UNCORR;
      end else if (evStat_r[MEES_EV_CORR]) begin
         curLvl = MEES_LVL_CORR;
      end else begin
         curLvl = MEES_LVL_NONE;
      end
      // Equal priority never overwrites
      capture = (newLvl > curLvl);                    // see (RULE_09)
   end

   // ==========================================================
   // Power-good synchroniser and halted negation detect
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         dcokMeta_r <= 1'b1;
         dcokSync_r <= 1'b1;
         dcokLast_r <= 1'b1;
      end else begin
         dcokMeta_r <= dcPowerGood;
         dcokSync_r <= dcokMeta_r;
         dcokLast_r <= dcokSync_r;
      end
   end

   // Only the second stage and its copy feed logic
   assign powerClr = dcokLast_r && !dcokSync_r && cpuHalted;

   // ==========================================================
   // Bus decode; writes land on the edge that ends the cycle with ack high,
   // so a master that abandons the cycle early never changes state
   always_comb begin
      busReq   = wb_cyc_i && wb_stb_i && !ack_r;
      wrStatus = wb_cyc_i && wb_stb_i && ack_r && wb_we_i && (wb_adr_i == MEES_OFF_STATUS);
      wrEvStat = wb_cyc_i && wb_stb_i && ack_r && wb_we_i && (wb_adr_i == MEES_OFF_INTSTAT) && wb_sel_i[0];
      wrEvMask = wb_cyc_i && wb_stb_i && ack_r && wb_we_i && (wb_adr_i == MEES_OFF_INTMASK) && wb_sel_i[0];
   end

   // ==========================================================
   // DMA error flag: set wins over the clear
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         errDma_r <= 1'b0;                            // see (RULE_04)
      end else if (dmaEv) begin
         errDma_r <= 1'b1;                            // see (RULE_01)
      end else if (powerClr) begin
         errDma_r <= 1'b0;                            // see (RULE_04)
      end else if (wrStatus && wb_sel_i[1] && wb_dat_i[MEES_DMA_BIT]) begin
         errDma_r <= 1'b0;                            // see (RULE_03)
      end
   end

   // ==========================================================
   // Bus parity error flag
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         errPar_r <= 1'b0;
      end else if (parBad) begin
         errPar_r <= 1'b1;                            // see (RULE_02)
      end else if (powerClr) begin
         errPar_r <= 1'b0;                            // see (RULE_04)
      end else if (wrStatus && wb_sel_i[0] && wb_dat_i[MEES_PAR_BIT]) begin
         errPar_r <= 1'b0;                            // see (RULE_03)
      end
   end

   // ==========================================================
   // Syndrome capture; software writes never reach it
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         synCap_r <= MEES_SYN_RST;
      end else if (capture) begin
         // A parity error records the code its poison will give
         synCap_r <= parBad ? MEES_SYN_PARITY : syn;  // see (RULE_09)
      end else if (powerClr) begin
         synCap_r <= MEES_SYN_RST;                    // see (RULE_04)
      end
   end

   // ==========================================================
   // Sticky events, one-to-clear, set wins
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         evStat_r <= MEES_EV_RST;
      end else begin
         for (int b = 0; b < MEES_EV_W; b++) begin
            if (powerClr || (wrEvStat && wb_dat_i[b])) begin
               evStat_r[b] <= 1'b0;
            end
         end
         if (dmaEv) begin
            evStat_r[MEES_EV_DMA] <= 1'b1;
         end
         if (parBad) begin
            evStat_r[MEES_EV_PAR] <= 1'b1;
         end
         if (uncorrEv) begin
            evStat_r[MEES_EV_UNCORR] <= 1'b1;         // see (RULE_08)
         end
         if (corrEv) begin
            evStat_r[MEES_EV_CORR] <= 1'b1;
         end
      end
   end

   // Mask register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         evMask_r <= MEES_EV_RST;
      end else if (wrEvMask) begin
         evMask_r <= wb_dat_i[MEES_EV_W-1:0];
      end
   end

   assign irq = |(evStat_r & evMask_r);

   // ==========================================================
   // Result registers toward the array and the requester
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         outValid_r <= 1'b0;
         outData_r  <= MEES_DATA_RST;
         outCheck_r <= MEES_SYN_RST;
      end else begin
         outValid_r <= refValid;
         if (refValid) begin
            outData_r  <= fixData;                    // see (RULE_15)
            outCheck_r <= wrCheck;                    // see (RULE_11)
         end
      end
   end

   assign outValid = outValid_r;
   assign outData  = outData_r;
   assign outCheck = outCheck_r;

   // ==========================================================
   // Wishbone answer: ack one cycle after the request
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_r   <= 1'b0;
         rdMux_r <= MEES_DATA_RST;
      end else begin
         ack_r <= busReq;
         case (wb_adr_i)
            MEES_OFF_STATUS: begin
               rdMux_r <= {23'h000000, errDma_r, errPar_r, synCap_r}; // see (RULE_05)
            end
            MEES_OFF_INTSTAT: begin
               rdMux_r <= {28'h0000000, evStat_r};
            end
            MEES_OFF_INTMASK: begin
               rdMux_r <= {28'h0000000, evMask_r};
            end
            default: begin
               // Unmapped offsets read zero and still acknowledge
               rdMux_r <= MEES_DATA_RST;
            end
         endcase
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdMux_r;

   // ==========================================================
   // Assertions
   property p_dma_set;
      @(posedge clk) disable iff (!reset_n) dmaEv |=> errDma_r;
   endproperty
   a_dma_set: assert property (p_dma_set) else $error("DMA flag not set"); // see (RULE_01)

   property p_par_set;
      @(posedge clk) disable iff (!reset_n)
         (refValid && refWrite && !refDma && busParErr) |=> errPar_r && evStat_r[MEES_EV_PAR];
   endproperty
   a_par_set: assert property (p_par_set) else $error("Parity flag not set"); // see (RULE_02)

   property p_zero_write;
      @(posedge clk) disable iff (!reset_n)
         (wrStatus && !wb_dat_i[MEES_DMA_BIT] && !wb_dat_i[MEES_PAR_BIT] && !powerClr)
            |=> ($stable(errDma_r) || errDma_r) && ($stable(errPar_r) || errPar_r);
   endproperty
   a_zero_write: assert property (p_zero_write) else $error("Zero write cleared flag"); // see (RULE_03)

   property p_power_clr;
      @(posedge clk) disable iff (!reset_n)
         (powerClr && !refValid) |=> !errDma_r && !errPar_r && (synCap_r == 7'h00);
   endproperty
   a_power_clr: assert property (p_power_clr) else $error("Power clear missed"); // see (RULE_04)

   property p_syn_ro;
      @(posedge clk) disable iff (!reset_n)
         (wrStatus && !capture && !powerClr) |=> $stable(synCap_r);
   endproperty
   a_syn_ro: assert property (p_syn_ro) else $error("Syndrome written by bus"); // see (RULE_05)

   property p_cap_nonzero;
      @(posedge clk) disable iff (!reset_n) (capture && eccErr) |=> synCap_r != 7'h00;
   endproperty
   a_cap_nonzero: assert property (p_cap_nonzero) else $error("Zero syndrome captured"); // see (RULE_06)

   property p_uncorr;
      @(posedge clk) disable iff (!reset_n)
         (eccChk && syn != 7'h00 && !single) |=> evStat_r[MEES_EV_UNCORR] && outValid_r;
   endproperty
   a_uncorr: assert property (p_uncorr) else $error("Uncorrectable not flagged"); // see (RULE_08)

   property p_no_overwrite;
      @(posedge clk) disable iff (!reset_n)
         (errPar_r && !powerClr && !(wrStatus && wb_dat_i[MEES_PAR_BIT])) |=> $stable(synCap_r);
   endproperty
   a_no_overwrite: assert property (p_no_overwrite) else $error("Captured syndrome overwritten"); // see (RULE_13)

   property p_poison;
      @(posedge clk) disable iff (!reset_n)
         parBad |=> (outCheck_r ^ mees_check_bits($past(wrData))) == 7'h07;
   endproperty
   a_poison: assert property (p_poison) else $error("Check bits not poisoned"); // see (RULE_11)

   property p_correct;
      @(posedge clk) disable iff (!reset_n)
         corrEv |=> $countones(outData_r ^ $past(rdData)) <= 1;
   endproperty
   a_correct: assert property (p_correct) else $error("Correction flipped several bits"); // see (RULE_15)

endmodule : mees_error_status

// [mees_pkg.sv]
/*
 * Shared constants for the memory ECC error status block: register map,
 * field positions, reset values and the single-bit syndrome columns.
 * Assumes a 32-bit data word stored with 7 check bits.
 */
package mees_pkg;

   // ==========================================================
   // Word geometry
   localparam int MEES_DATA_W  = 32;                  // Data bits per word
   localparam int MEES_CHECK_W = 7;                   // Check bits per word
   localparam int MEES_WORD_W  = 39;                  // Stored array word

   // ==========================================================
   // Register map (byte offsets on the bus)
   localparam logic [3:0] MEES_OFF_STATUS  = 4'h0;   // memory_error_status
   localparam logic [3:0] MEES_OFF_INTSTAT = 4'h4;   // Sticky event bits
   localparam logic [3:0] MEES_OFF_INTMASK = 4'h8;   // Event mask

   // ==========================================================
   // memory_error_status fields
   localparam int MEES_DMA_BIT = 8;                   // DMA error flag
   localparam int MEES_PAR_BIT = 7;                   // Bus parity error flag
   localparam int MEES_SYN_LSB = 0;                   // Syndrome <6:0>

   // Event bits shared by status and mask registers
   localparam int MEES_EV_W      = 4;
   localparam int MEES_EV_DMA    = 0;
   localparam int MEES_EV_PAR    = 1;
   localparam int MEES_EV_UNCORR = 2;
   localparam int MEES_EV_CORR   = 3;

   // Reset values
   localparam logic [6:0]  MEES_SYN_RST  = 7'h00;
   localparam logic [3:0]  MEES_EV_RST   = 4'h0;
   localparam logic [31:0] MEES_DATA_RST = 32'h0000_0000;

   // Syndrome left by deliberately wrong check bits on a parity error
   localparam logic [6:0] MEES_SYN_PARITY = 7'h07;

   // Capture priority levels
   typedef enum logic [1:0] {
      MEES_LVL_NONE   = 2'b00,
      MEES_LVL_CORR   = 2'b01,
      MEES_LVL_UNCORR = 2'b10,
      MEES_LVL_PAR    = 2'b11
   } mees_level_t;

   // ==========================================================
   // Syndrome of a single error in each data bit
   localparam logic [6:0] MEES_COL [0:31] = '{
      7'h58, 7'h1C, 7'h1A, 7'h5E, 7'h1F, 7'h5B, 7'h5D, 7'h19,
      7'h68, 7'h2C, 7'h2A, 7'h6E, 7'h2F, 7'h6B, 7'h6D, 7'h29,
      7'h70, 7'h34, 7'h32, 7'h76, 7'h37, 7'h73, 7'h75, 7'h31,
      7'h38, 7'h7C, 7'h7A, 7'h3E, 7'h7F, 7'h3B, 7'h3D, 7'h79};

   // Check bits for a data word; check bit k sits alone in column 32+k
   function automatic logic [6:0] mees_check_bits(input logic [31:0] d);
      logic [6:0] c;
      c = 7'h00;
      for (int i = 0; i < 32; i++) begin
         if (d[i]) begin
            c = c ^ MEES_COL[i];
         end
      end
      return c;
   endfunction : mees_check_bits

endpackage : mees_pkg

// [mees_syn_decode.sv]
/*
 * Syndrome former and single-bit decoder for one read word.
 * Purely combinational; the caller registers the results.
 */
`timescale 1ns/1ps
module mees_syn_decode
   import mees_pkg::*;
(
   input  wire logic [31:0] rdData,      // Data read from the array
   input  wire logic [6:0]  rdCheck,     // Check bits read from the array
   output logic      [6:0]  syndrome,    // Zero when no error
   output logic             singleHit,   // Syndrome matches one bit
   output logic      [31:0] fixData      // Data with the bad bit inverted
);

   // ==========================================================
   // Syndrome and match against every single-bit code
   always_comb begin
      syndrome  = rdCheck ^ mees_check_bits(rdData);   // see (RULE_15)
      singleHit = 1'b0;
      fixData   = rdData;
      // Data columns: invert the matching data bit
      for (int i = 0; i < 32; i++) begin
         if (syndrome == MEES_COL[i]) begin             // see (RULE_12)
            singleHit  = 1'b1;
            fixData[i] = ~rdData[i];                    // see (RULE_15)
         end
      end
      // Check-bit errors are one-hot; data needs no repair
      for (int k = 0; k < 7; k++) begin
         if (syndrome == (7'h01 << k)) begin            // see (RULE_10)
            singleHit = 1'b1;
         end
      end
   end

endmodule : mees_syn_decode

// [mees_write_encode.sv]
/*
 * Check-bit generator for the word about to be written.
 * Assumes the parity verdict arrives with the data in the same cycle.
 */
`timescale 1ns/1ps
module mees_write_encode
   import mees_pkg::*;
(
   input  wire logic [31:0] wrData,      // Data to be stored
   input  wire logic        parBad,      // Bus parity failed on this write
   output logic      [6:0]  wrCheck      // Check bits to store
);

   // ==========================================================
   // Poison on parity failure so a later read flags the word
   always_comb begin
      wrCheck = mees_check_bits(wrData);
      if (parBad) begin
         wrCheck = wrCheck ^ MEES_SYN_PARITY;            // see (RULE_11)
      end
   end

endmodule : mees_write_encode

// [mees_ref_master.sv]
/* Reference master model: presents one memory reference at a time.
   Assumes the bench calls refOp and the block answers one cycle later. */
`timescale 1ns/1ps
module mees_ref_master (
   input  wire logic        clk,        // Controller clock
   output logic             refValid,   // Reference strobe
   output logic             refDma,     // DMA master
   output logic             refWrite,   // Write reference
   output logic             refMasked,  // Masked write
   output logic             busParErr,  // Bus parity failed
   output logic      [31:0] rdData,     // Array read data
   output logic      [6:0]  rdCheck,    // Array check bits
   output logic      [31:0] wrData      // Write data
);
   // ==========================================
   // Idle lines at time zero
   initial begin
      {refValid, refDma, refWrite, refMasked, busParErr} = 5'h00;
      {rdData, rdCheck, wrData} = 71'h0;
   end
   // Kind is {dma, write, masked, parity}; stale lines are inverted
   // afterwards so a leftover value never looks like a real word
   task automatic refOp(input logic [3:0] kind, input logic [31:0] rd, input logic [6:0] ck, input logic [31:0] wd);
      @(posedge clk);
      refValid <= 1'b1;
      {refDma, refWrite, refMasked, busParErr} <= kind;
      {rdData, rdCheck, wrData} <= {rd, ck, wd};
      @(posedge clk);
      refValid <= 1'b0;
      {rdData, rdCheck, wrData} <= ~{rd, ck, wd};
   endtask : refOp
endmodule : mees_ref_master

// [mees_error_status_bench.sv]
/* Self-checking bench for the memory ECC error status block.
   Assumes the package and the reference master model compile first. */
`timescale 1ns/1ps
module mees_error_status_bench
   import mees_pkg::*;
;
   // ==========================================
   // Signals
   logic        clk = 1'b0, resetN, wbCyc, wbStb, wbWe, wbAck, dcPowerGood, cpuHalted;
   logic        refValid, refDma, refWrite, refMasked, busParErr, outValid, irq;
   logic [3:0]  wbAdr, wbSel;
   logic [6:0]  rdCheck, outCheck;
   logic [31:0] wbDatI, wbDatO, rdData, wrData, outData, q;
   int          errCount, nCompared;
   // Single-bit cases: flipped data bits 0, 1, 31 and check bits 32, 38
   localparam logic [31:0] SD [0:4] = '{32'h1, 32'h2, 32'h8000_0000, 32'h0, 32'h0};
   localparam logic [6:0]  SC [0:4] = '{7'h00, 7'h00, 7'h00, 7'h01, 7'h40};
   localparam logic [6:0]  SS [0:4] = '{7'h58, 7'h1C, 7'h79, 7'h01, 7'h40};

   always #2.5 clk = ~clk;

   mees_error_status u_dut (.clk(clk), .reset_n(resetN), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
      .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
      .wb_ack_o(wbAck), .refValid(refValid), .refDma(refDma), .refWrite(refWrite),
      .refMasked(refMasked), .busParErr(busParErr), .rdData(rdData), .rdCheck(rdCheck),
      .wrData(wrData), .dcPowerGood(dcPowerGood), .cpuHalted(cpuHalted), .outValid(outValid),
      .outData(outData), .outCheck(outCheck), .irq(irq));
   mees_ref_master u_ref (.clk(clk), .refValid(refValid), .refDma(refDma), .refWrite(refWrite),
      .refMasked(refMasked), .busParErr(busParErr), .rdData(rdData), .rdCheck(rdCheck), .wrData(wrData));

   // ==========================================
   // Shared tasks
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      nCompared++;
      if (got !== exp) begin
         errCount++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   // Classic single cycle; the slave latency is never assumed
   task automatic wb(input logic we, input logic [3:0] adr, input logic [3:0] sel, input logic [31:0] d);
      @(posedge clk);
      {wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatI} <= {2'b11, we, adr, sel, d};
      // Only the watchdog ends a wait that never sees ack
      do begin
         @(posedge clk);
      end while (wbAck !== 1'b1);
      q = wbDatO;
      {wbCyc, wbStb, wbWe} <= 3'h0;
   endtask : wb
   task automatic rdx(input logic [3:0] adr, input logic [31:0] exp, input string name);
      wb(1'b0, adr, 4'hF, 32'h0);
      chk(name, exp, q);
   endtask : rdx
   task automatic doRef(input logic [3:0] kind, input logic [31:0] rd, input logic [6:0] ck, input logic [31:0] wd);
      u_ref.refOp(kind, rd, ck, wd);
      #1;
      chk("outValid", 32'h1, {31'h0, outValid});
   endtask : doRef
   task automatic chkIrq(input logic exp);
      #1;
      chk("irq", {31'h0, exp}, {31'h0, irq});
   endtask : chkIrq

   // ==========================================
   // Scenarios
   task automatic t_reset();
      rdx(4'h0, 32'h0, "status");
      rdx(4'h4, 32'h0, "event");
      rdx(4'h8, 32'h0, "mask");
      rdx(4'hC, 32'h0, "unmapped");
      doRef(4'h0, 32'h1, 7'h58, 32'h0);
      chk("clean data", 32'h1, outData);
      rdx(4'h0, 32'h0, "clean syndrome");
      $display("reset test done");
   endtask : t_reset
   task automatic t_single();
      for (int i = 0; i < 5; i++) begin
         doRef(4'h0, SD[i], SC[i], 32'h0);
         chk("corrected", 32'h0, outData);
         rdx(4'h0, {25'h0, SS[i]}, "syndrome");
         rdx(4'h4, 32'h8, "correctable event");
         wb(1'b1, 4'h4, 4'hF, 32'hF);
      end
      $display("single-bit test done");
   endtask : t_single
   task automatic t_prio();
      doRef(4'h0, 32'h1, 7'h00, 32'h0);
      doRef(4'h0, 32'h3, 7'h00, 32'h0);
      rdx(4'h0, 32'h44, "uncorrectable wins");
      doRef(4'h0, 32'h2, 7'h00, 32'h0);
      doRef(4'h0, 32'h5, 7'h00, 32'h0);
      rdx(4'h0, 32'h44, "no overwrite");
      doRef(4'h4, 32'h0, 7'h00, 32'h1);
      chk("clean check", 32'h58, {25'h0, outCheck});
      doRef(4'h5, 32'h0, 7'h00, 32'h0);
      chk("poisoned check", 32'h07, {25'h0, outCheck});
      rdx(4'h0, 32'h87, "parity capture");
      rdx(4'h4, 32'hE, "events");
      wb(1'b1, 4'h0, 4'h1, 32'h7F);
      rdx(4'h0, 32'h87, "zero and read-only");
      wb(1'b1, 4'h0, 4'h1, 32'h80);
      rdx(4'h0, 32'h07, "parity cleared");
      wb(1'b1, 4'h4, 4'hF, 32'hF);
      $display("priority test done");
   endtask : t_prio
   task automatic t_dma();
      doRef(4'h8, 32'h8000_0000, 7'h00, 32'h0);
      rdx(4'h0, 32'h179, "dma flag");
      doRef(4'hD, 32'h0, 7'h00, 32'h0);
      rdx(4'h0, 32'h179, "dma write parity");
      wb(1'b1, 4'h0, 4'h2, 32'h100);
      rdx(4'h0, 32'h79, "dma cleared");
      wb(1'b1, 4'h4, 4'hF, 32'hF);
      doRef(4'h6, 32'h0, 7'h01, 32'h0);
      rdx(4'h0, 32'h01, "masked write");
      rdx(4'h4, 32'h8, "masked event");
      $display("dma test done");
   endtask : t_dma
   task automatic t_irq();
      chkIrq(1'b0);
      wb(1'b1, 4'h8, 4'hF, 32'h8);
      chkIrq(1'b1);
      rdx(4'h8, 32'h8, "mask");
      wb(1'b1, 4'h4, 4'hF, 32'h8);
      chkIrq(1'b0);
      $display("interrupt test done");
   endtask : t_irq
   task automatic t_pgood();
      doRef(4'h8, 32'h1, 7'h00, 32'h0);
      chkIrq(1'b1);
      @(posedge clk);
      dcPowerGood <= 1'b0;
      repeat (6) @(posedge clk);
      rdx(4'h0, 32'h158, "running drop");
      dcPowerGood <= 1'b1;
      repeat (6) @(posedge clk);
      cpuHalted <= 1'b1;
      dcPowerGood <= 1'b0;
      repeat (6) @(posedge clk);
      rdx(4'h0, 32'h0, "halted drop");
      rdx(4'h4, 32'h0, "events dropped");
      chkIrq(1'b0);
      $display("power-good test done");
   endtask : t_pgood

   // ==========================================
   // Verdict, main sequence and watchdog
   task automatic completeRun();
      $display("compared %0d mismatches %0d", nCompared, errCount);
      if (errCount == 0 && nCompared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : completeRun
   initial begin
      {resetN, wbCyc, wbStb, wbWe, cpuHalted, dcPowerGood} = 6'h01;
      {wbAdr, wbSel, wbDatI} = 40'h0;
      {errCount, nCompared} = 64'h0;
      repeat (5) @(posedge clk);
      resetN <= 1'b1;
      t_reset();
      t_single();
      t_prio();
      t_dma();
      t_irq();
      t_pgood();
      completeRun();
   end
   initial begin
      repeat (5000) @(posedge clk);
      errCount++;
      completeRun();
   end
endmodule : mees_error_status_bench
